/* src/nqp_core.sv */
`timescale 1ns/100ps
// serial command interpreter of the quad nonvolatile potentiometer
module nqp_core #(
    parameter int SAVE_CYC = nqp_pkg::SAVE_CYC,
    parameter int RESTORE_CYC = nqp_pkg::RESTORE_CYC,
    parameter int READ_CYC = nqp_pkg::READ_CYC,
    parameter int PRESET_CYC = nqp_pkg::PRESET_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic sclk_link,
    input wire logic sdi,
    input wire logic cs_n,
    input wire logic preset_n,
    input wire logic wp_n,
    output logic sdo_o,
    output logic sdo_oe_n,
    output logic rdy_o,
    output logic rdy_oe_n,
    output logic nv_output_one,
    output logic nv_output_two,
    output logic [3:0][5:0] wiper_pos
);
    nqp_pkg::nqp_state_type state_q;
    logic [nqp_pkg::TMR_W-1:0] tmr_q;
    logic busy;
    logic [1:0] lrst_q;
    logic [1:0] lbusy_q;
    logic [15:0] sr_q;
    logic [3:0] cnt_q;
    logic tgl_q;
    logic [15:0] rb_q;
    logic rb_mode_q;
    logic [2:0] cs_q;
    logic [2:0] pre_q;
    logic [1:0] wp_q;
    logic [1:0] ft_q;
    logic seen_q;
    logic pwr_q;
    nqp_pkg::nqp_word_type last_q;
    nqp_pkg::nqp_word_type word;
    logic [3:0][5:0] wiper_q;
    logic [7:0] mem_q [nqp_pkg::NV_DEPTH];

    assign busy = (state_q == nqp_pkg::ST_BUSY);

    // reset and busy lock brought onto the serial clock
    always_ff @(posedge sclk_link) begin
        lrst_q <= {lrst_q[0], reset_n};
        lbusy_q <= {lbusy_q[0], busy};
    end

    wire lrst_n = lrst_q[1];
    wire shift_en = ~lbusy_q[1];

    // msb-first shift on rising serial clock
    // shifting frozen while a slow operation runs
    always_ff @(posedge sclk_link) begin
        if (!lrst_n) begin
            sr_q <= 16'h0000;
            cnt_q <= 4'h0;
            tgl_q <= 1'b0;
        end else if (shift_en) begin
            sr_q <= {sr_q[14:0], sdi};
            cnt_q <= cnt_q + 4'h1;
            // word-complete toggle is the handshake to the system side
            if (cnt_q == 4'hF) begin
                tgl_q <= ~tgl_q;
            end
        end
    end

    // readback word walks out msb first
    wire rb_bit = rb_q[4'hF - cnt_q];
    // otherwise the bit shifted in sixteen clocks ago
    wire sdo_bit = rb_mode_q ? rb_bit : sr_q[15];
    assign sdo_o = 1'b0;
    // open drain released while chip select is high
    assign sdo_oe_n = cs_n | sdo_bit;

    // pin synchronisers; third stage only for edge detection
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cs_q <= 3'b111;
            pre_q <= 3'b111;
            wp_q <= 2'b11;
            ft_q <= 2'b00;
        end else begin
            cs_q <= {cs_q[1:0], cs_n};
            pre_q <= {pre_q[1:0], preset_n};
            wp_q <= {wp_q[0], wp_n};
            ft_q <= {ft_q[0], tgl_q};
        end
    end

    wire cs_rise = cs_q[1] & ~cs_q[2];
    wire pre_low = ~pre_q[1];
    wire pre_rise = pre_q[1] & ~pre_q[2];
    wire prot = ~wp_q[1];
    // shift register is quiet once chip select is high, so it is read directly
    wire fresh = ft_q[1] ^ seen_q;

    // no new word: the last adjustment is replayed
    assign word = fresh ? nqp_pkg::nqp_word_type'(sr_q) : last_q;
    wire [3:0] cmd = word.cmd;
    wire repeat_ok = last_q.cmd[2];
    // act only on the chip select rising edge
    wire go = cs_rise & ~busy & ~pre_low & ~pre_rise & (fresh | repeat_ok);
    wire in_ch = (word.addr < nqp_pkg::ADDR_OUTS);
    // protect gates every change but restore
    wire wr_ok = go & ~prot;

    // command decode; code 0 matches no term
    wire do_wr = wr_ok & (cmd == nqp_pkg::C_WR) & in_ch;
    wire do_adj = wr_ok & cmd[2];
    wire do_one = go & (cmd == nqp_pkg::C_RESTORE) & in_ch;
    wire do_rst = go & (cmd == nqp_pkg::C_RESET);
    // reload all wipers from the store
    wire do_all = do_rst | pre_rise | pwr_q;
    wire do_sv2 = wr_ok & (cmd == nqp_pkg::C_SAVE) & in_ch;
    wire do_sv = do_sv2 | (wr_ok & (cmd == nqp_pkg::C_SAVE_USER));
    wire do_rb = go & ((cmd == nqp_pkg::C_RD_NV) | (cmd == nqp_pkg::C_RD_WIPER));
    wire slow = do_sv | do_rb | do_rst | pre_rise;

    // busy time of each slow operation
    wire [nqp_pkg::TMR_W-1:0] t_load = pre_rise ? nqp_pkg::TMR_W'(PRESET_CYC - 1) :
        do_rst ? nqp_pkg::TMR_W'(RESTORE_CYC - 1) :
        do_rb ? nqp_pkg::TMR_W'(READ_CYC - 1) : nqp_pkg::TMR_W'(SAVE_CYC - 1);

    // word bookkeeping for the repeat feature
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            seen_q <= 1'b0;
            last_q <= '0;
            pwr_q <= 1'b1;
        end else begin
            pwr_q <= 1'b0;
            if (cs_rise) begin
                seen_q <= ft_q[1];
            end
            if (cs_rise & fresh) begin
                last_q <= nqp_pkg::nqp_word_type'(sr_q);
            end
        end
    end

    // per-channel wiper registers and adjusters
    for (genvar g = 0; g < nqp_pkg::NCH; g++) begin : g_ch
        logic [5:0] w;
        logic [5:0] up6;
        logic [5:0] dn6;
        logic [5:0] up1;
        logic [5:0] dn1;
        logic [5:0] adj;
        wire hit = (word.addr == 4'(g));
        assign w = wiper_q[g];
        assign up6 = w[5] ? nqp_pkg::MAX_CODE : {w[4:0], 1'b0};
        assign dn6 = {1'b0, w[5:1]};
        assign up1 = (w == nqp_pkg::MAX_CODE) ? nqp_pkg::MAX_CODE : w + 6'h01;
        assign dn1 = (w == nqp_pkg::MIN_CODE) ? nqp_pkg::MIN_CODE : w - 6'h01;
        assign adj = cmd[3] ? (cmd[1] ? up1 : up6) : (cmd[1] ? dn1 : dn6);

        // preset low wins; six data bits on write
        always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
                wiper_q[g] <= nqp_pkg::MID_CODE;
            end else if (pre_low) begin
                wiper_q[g] <= nqp_pkg::MID_CODE;
            end else if (do_all | (do_one & hit)) begin
                wiper_q[g] <= mem_q[g][5:0];
            end else if (do_wr & hit) begin
                wiper_q[g] <= word.data[5:0];
            end else if (do_adj & (cmd[0] | hit)) begin
                wiper_q[g] <= adj;
            end
        end
    end

    // position outputs follow the wiper registers
    assign wiper_pos = wiper_q;

    // data written into the nonvolatile store
    wire [7:0] sv_data = do_sv2 ? {2'b00, wiper_q[word.addr[1:0]]} :
        in_ch ? {2'b00, word.data[5:0]} :
        (word.addr == nqp_pkg::ADDR_OUTS) ? {6'h00, word.data[1:0]} : word.data;

    // factory contents: midscale wipers, outputs high
    for (genvar e = 0; e < nqp_pkg::NV_DEPTH; e++) begin : g_nv
        localparam logic [7:0] RV = (e < nqp_pkg::NCH) ? {2'b00, nqp_pkg::MID_CODE} :
            (e == int'(nqp_pkg::ADDR_OUTS)) ? nqp_pkg::OUTS_RESET : nqp_pkg::USER_RESET;
        always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
                mem_q[e] <= RV;
            end else if (do_sv & (word.addr == 4'(e))) begin
                mem_q[e] <= sv_data;
            end
        end
    end

    // outputs driven from store bits d0 and d1
    assign nv_output_one = mem_q[nqp_pkg::ADDR_OUTS][0];
    assign nv_output_two = mem_q[nqp_pkg::ADDR_OUTS][1];

    // readback value; out-of-range wiper address reads zero
    wire [5:0] w_sel = in_ch ? wiper_q[word.addr[1:0]] : nqp_pkg::MIN_CODE;
    wire [7:0] rb_val = (cmd == nqp_pkg::C_RD_NV) ? mem_q[word.addr] : {2'b00, w_sel};

    // readback word; stable while the host waits for ready
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rb_q <= 16'h0000;
            rb_mode_q <= 1'b0;
        end else if (go) begin
            rb_mode_q <= do_rb;
            if (do_rb) begin
                rb_q <= {8'h00, rb_val};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_q <= nqp_pkg::ST_IDLE;
            tmr_q <= '0;
        end else begin
            unique case (state_q)
                nqp_pkg::ST_IDLE: begin
                    if (slow) begin
                        state_q <= nqp_pkg::ST_BUSY;
                        tmr_q <= t_load;
                    end
                end
                nqp_pkg::ST_BUSY: begin
                    if (tmr_q == '0) begin
                        state_q <= nqp_pkg::ST_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 1'b1;
                    end
                end
            endcase
        end
    end

    // ready open drain: pulled low while busy or preset held
    assign rdy_o = 1'b0;
    assign rdy_oe_n = ~(busy | pre_low);

    // checks; shift and lock ones run on the serial clock
    property p_shift;
        @(posedge sclk_link) disable iff (!lrst_n) shift_en |=> sr_q[0] == $past(sdi);
    endproperty
    a_shift: assert property (p_shift) else $error("serial bit not captured");

    property p_decode;
        @(posedge clk_sys) disable iff (!reset_n) $rose(busy) |-> $past(cs_rise) || $past(pre_rise);
    endproperty
    a_decode: assert property (p_decode) else $error("busy without strobe");

    property p_outs;
        @(posedge clk_sys) disable iff (!reset_n) $rose(reset_n) |-> nv_output_one && nv_output_two;
    endproperty
    a_outs: assert property (p_outs) else $error("outputs not high");

    property p_write;
        @(posedge clk_sys) disable iff (!reset_n)
            do_wr && word.addr == 4'h0 && !do_all |=> wiper_pos[0] == $past(word.data[5:0]);
    endproperty
    a_write: assert property (p_write) else $error("wiper write lost");

    property p_prot;
        @(posedge clk_sys) disable iff (!reset_n)
            go && prot && cmd == nqp_pkg::C_WR && !pwr_q |=> $stable(wiper_pos);
    endproperty
    a_prot: assert property (p_prot) else $error("write under protect");

    property p_preset;
        @(posedge clk_sys) disable iff (!reset_n)
            pre_rise && !pwr_q |=> wiper_pos[1] == $past(mem_q[1][5:0]);
    endproperty
    a_preset: assert property (p_preset) else $error("preset reload wrong");

    property p_save_rdy;
        @(posedge clk_sys) disable iff (!reset_n) do_sv2 |=> !rdy_oe_n [*8];
    endproperty
    a_save_rdy: assert property (p_save_rdy) else $error("ready high in save");

    property p_lock;
        @(posedge sclk_link) disable iff (!lrst_n) lbusy_q[1] |=> $stable(sr_q);
    endproperty
    a_lock: assert property (p_lock) else $error("shift during lock");

    property p_nop;
        @(posedge clk_sys) disable iff (!reset_n) go && cmd == nqp_pkg::C_NOP && !pwr_q |=> $stable(wiper_pos);
    endproperty
    a_nop: assert property (p_nop) else $error("nop changed wiper");

    property p_mid;
        @(posedge clk_sys) disable iff (!reset_n) pre_low |=> wiper_pos[2] == nqp_pkg::MID_CODE;
    endproperty
    a_mid: assert property (p_mid) else $error("preset low not midscale");

    property p_release;
        @(posedge clk_sys) disable iff (!reset_n) cs_n |-> sdo_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("sdo driven with cs high");

    property p_sat;
        @(posedge clk_sys) disable iff (!reset_n) do_adj && cmd == nqp_pkg::C_INC1 &&
            word.addr == 4'h3 && wiper_pos[3] == nqp_pkg::MAX_CODE && !do_all |=>
            wiper_pos[3] == nqp_pkg::MAX_CODE;
    endproperty
    a_sat: assert property (p_sat) else $error("increment wrapped");

    c_write: cover property (@(posedge clk_sys) disable iff (!reset_n) do_wr);
    c_save: cover property (@(posedge clk_sys) disable iff (!reset_n) do_sv2 ##1 busy [*2]);
    c_repeat: cover property (@(posedge clk_sys) disable iff (!reset_n) go && !fresh);
    c_read: cover property (@(posedge clk_sys) disable iff (!reset_n) do_rb);
endmodule

/* pkg/nqp_pkg.sv */
// constants and types of the quad potentiometer serial control block
// What this block does
// - host sends msb first; device samples serial input on each rising serial clock
// - captured word is decoded and executed only when chip select returns high
// - only commands 9 and 10 put register contents on the serial output
// - other commands replay serial input delayed by 16 clocks for daisy chains
// - two nonvolatile outputs at address 4, bits d0 and d1, start at one
// - wiper registers of channels one to four sit at addresses 0 to 3
// - write protect blocks all changes except preset and restore commands 1 and 8
// - rising edge of preset reloads every wiper from its nonvolatile copy
// - nonvolatile wiper copies hold midscale 32 until the user saves a value
// - ready is high when idle, low during commands 2,3,8,9,10 and preset
// - each wiper position output follows its wiper register
// - after power-up each wiper is loaded from its nonvolatile copy
// - a save lasts 25 ms; shift register is locked, host waits ready
// - sixteen instruction codes are decoded; code 0 changes nothing
// - codes map to restore, save, adjust, reset, read, write and increment
// - words are 16 bits of command, address, data; wipers use six data bits
// - preset held low forces wipers to midscale at once
// - a chip select strobe without new data repeats the last adjustment
package nqp_pkg;
    localparam int NCH = 4;
    localparam int NV_DEPTH = 16;
    localparam int TMR_W = 22;
    localparam logic [5:0] MID_CODE = 6'h20;
    localparam logic [5:0] MAX_CODE = 6'h3F;
    localparam logic [5:0] MIN_CODE = 6'h00;
    localparam logic [3:0] ADDR_OUTS = 4'h4;
    localparam logic [7:0] OUTS_RESET = 8'h03;
    localparam logic [7:0] USER_RESET = 8'h00;
    localparam int CLK_MHZ = 100;
    localparam int SAVE_TIME_MS = 25;
    localparam int RESTORE_TIME_US = 1000;
    localparam int READ_TIME_US = 120;
    localparam int PRESET_TIME_US = 50;
    localparam int SAVE_CYC = SAVE_TIME_MS * 1000 * CLK_MHZ;
    localparam int RESTORE_CYC = RESTORE_TIME_US * CLK_MHZ;
    localparam int READ_CYC = READ_TIME_US * CLK_MHZ;
    localparam int PRESET_CYC = PRESET_TIME_US * CLK_MHZ;

    typedef enum logic [3:0] {
        C_NOP = 4'h0, C_RESTORE = 4'h1, C_SAVE = 4'h2, C_SAVE_USER = 4'h3,
        C_DEC6 = 4'h4, C_DEC6_ALL = 4'h5, C_DEC1 = 4'h6, C_DEC1_ALL = 4'h7,
        C_RESET = 4'h8, C_RD_NV = 4'h9, C_RD_WIPER = 4'hA, C_WR = 4'hB,
        C_INC6 = 4'hC, C_INC6_ALL = 4'hD, C_INC1 = 4'hE, C_INC1_ALL = 4'hF
    } nqp_cmd_type;

    typedef enum logic {ST_IDLE = 1'b0, ST_BUSY = 1'b1} nqp_state_type;

    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] addr;
        logic [7:0] data;
    } nqp_word_type;
endpackage

/* bench/nqp_host.sv */
// serial host model that drives the potentiometer link
`timescale 1ns/100ps
module nqp_host (
    output logic sclk_link,
    output logic sdi,
    output logic cs_n,
    input wire logic sdo,
    output logic [15:0] rx
);
    // link clock idles low; it runs inside frames and in the idle pulses around reset release
    initial begin
        sclk_link = 1'b0;
        sdi = 1'b0;
        cs_n = 1'b1;
        rx = 16'h0000;
    end
    // pulses with chip select high around reset release: three clear the link side,
    // the last two carry the release through the link reset synchroniser
    task automatic idle_clocks();
        repeat (5) begin
            #30 sclk_link = 1'b1;
            #30 sclk_link = 1'b0;
        end
    endtask
    // one frame; sdo is sampled just before each rising edge
    task automatic xfer(input logic [15:0] w);
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi = w[i];
            #40 rx[i] = sdo;
            sclk_link = 1'b1;
            #40 sclk_link = 1'b0;
        end
        #40 cs_n = 1'b1;
        // released data line must not keep showing its last bit
        sdi = ~w[0];
        #200;
    endtask
    // strobe with no clock edges, used to repeat an adjustment
    task automatic strobe();
        cs_n = 1'b0;
        #80 cs_n = 1'b1;
        #200;
    endtask
endmodule

/* bench/tb_nqp_core.sv */
// self-checking bench of the quad potentiometer serial control
`timescale 1ns/100ps
module tb_nqp_core;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic preset_n = 1'b1;
    logic wp_n = 1'b1;
    logic sclk_link, sdi, cs_n, sdo_o, sdo_oe_n, rdy_o, rdy_oe_n, nv_output_one, nv_output_two;
    logic [3:0][5:0] wiper_pos;
    logic [15:0] rx;
    int errors = 0;
    int cmp_count = 0;
    // adjustment table on channel four, with the code each step leaves
    logic [15:0] ops [9] = '{16'hB310, 16'hC300, 16'hE300, 16'h6300, 16'h4300,
        16'hD300, 16'hF300, 16'h7300, 16'h5300};
    logic [5:0] res [9] = '{6'h10, 6'h20, 6'h21, 6'h20, 6'h10, 6'h20, 6'h21, 6'h20, 6'h10};
    // open-drain pins with pull-ups
    wire sdo_line = sdo_oe_n ? 1'b1 : sdo_o;
    wire rdy_line = rdy_oe_n ? 1'b1 : rdy_o;

    always #5 clk_sys = ~clk_sys;

    nqp_core #(.SAVE_CYC(40), .RESTORE_CYC(20), .READ_CYC(12), .PRESET_CYC(10)) nqp_core_i (
        .clk_sys(clk_sys), .reset_n(reset_n), .sclk_link(sclk_link), .sdi(sdi), .cs_n(cs_n),
        .preset_n(preset_n), .wp_n(wp_n), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .rdy_o(rdy_o),
        .rdy_oe_n(rdy_oe_n), .nv_output_one(nv_output_one), .nv_output_two(nv_output_two),
        .wiper_pos(wiper_pos));
    nqp_host nqp_host_i (.sclk_link(sclk_link), .sdi(sdi), .cs_n(cs_n), .sdo(sdo_line), .rx(rx));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkw(input int ch, input logic [5:0] exp);
        chk({10'h000, wiper_pos[ch]}, {10'h000, exp});
    endtask
    task automatic end_of_test();
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // bounded wait for the ready pin; running out ends the run
    task automatic wait_rdy();
        int n;
        n = 0;
        while (rdy_line !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        if (rdy_line !== 1'b1) begin
            errors++;
            end_of_test();
        end
    endtask
    task automatic send(input logic [15:0] w);
        nqp_host_i.xfer(w);
    endtask

    initial begin
        // reset for 20 cycles; link pulses at 30 + 60k ns, two of them after the release
        fork
            nqp_host_i.idle_clocks();
            begin
                repeat (20) @(negedge clk_sys);
                reset_n = 1'b1;
            end
        join
        repeat (6) @(negedge clk_sys);
        for (int c = 0; c < 4; c++) begin
            chkw(c, 6'h20);
        end
        chk({14'h0000, nv_output_two, nv_output_one}, 16'h0003);
        chk({15'h0000, rdy_line}, 16'h0001);
        // upper data bits must be dropped when loading a wiper
        for (int c = 0; c < 4; c++) begin
            send({4'hB, c[3:0], 8'hC8 + c[7:0]});
        end
        for (int c = 0; c < 4; c++) begin
            chkw(c, 6'h08 + c[5:0]);
        end
        send(16'h0000);
        chk(rx, 16'hB3CB);
        chk({15'h0000, sdo_line}, 16'h0001);
        for (int k = 0; k < 9; k++) begin
            send(ops[k]);
            chkw(3, res[k]);
        end
        // saturation and repeat on bare strobes
        send(16'hB33E);
        send(16'hE300);
        chkw(3, 6'h3F);
        nqp_host_i.strobe();
        chkw(3, 6'h3F);
        send(16'h6300);
        nqp_host_i.strobe();
        chkw(3, 6'h3D);
        send(16'hB301);
        send(16'h6300);
        nqp_host_i.strobe();
        chkw(3, 6'h00);
        // readback shows up in the following frame only
        send(16'hB32A);
        send(16'hA300);
        wait_rdy();
        send(16'h0000);
        chk(rx, 16'h002A);
        // save, then restore one channel from the store; readback mode is over by now
        send(16'hB010);
        chk(rx, 16'h0000);
        send(16'h2000);
        chk({15'h0000, rdy_line}, 16'h0000);
        wait_rdy();
        send(16'hB005);
        send(16'h1000);
        chkw(0, 6'h10);
        // write protect blocks writes but not a full restore
        send(16'hB115);
        @(negedge clk_sys) wp_n = 1'b0;
        send(16'hB100);
        chkw(1, 6'h15);
        send(16'h8000);
        wait_rdy();
        chkw(1, 6'h20);
        chkw(0, 6'h10);
        send(16'h0000);
        @(negedge clk_sys) wp_n = 1'b1;
        // nonvolatile output bits
        send(16'h3402);
        wait_rdy();
        chk({14'h0000, nv_output_two, nv_output_one}, 16'h0002);
        // preset low forces midscale, release reloads the store
        send(16'hB03F);
        @(negedge clk_sys) preset_n = 1'b0;
        repeat (6) @(negedge clk_sys);
        chkw(0, 6'h20);
        preset_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk({15'h0000, rdy_line}, 16'h0000);
        wait_rdy();
        chkw(0, 6'h10);
        end_of_test();
    end
endmodule
